// File: eatd_top.sv
// External analog trigger detector: Avalon-MM register slave, level compare and edge or level detection.
// Assumes one clock, sample words from converter logic on the same clock, and an
// Avalon-MM master that holds each request until it sees waitrequest low.
//
// Contract
// - Read-only bitmask of supported detection modes.
// - Read/write mode register selects one behaviour.
// - Disabled mode never produces a detection.
// - Rising edge: below-to-above crossing triggers.
// - Falling edge: above-to-below crossing triggers.
// - Any edge: every crossing triggers.
// - Above-level mode triggers while input above.
// - Below-level mode triggers while input below.
// - Detection used only when masked in.
// - Termination select: one 50 ohm, zero high.
// - Every active mode compares against the level.
// - Read/write level in mV, within limits.
// - Read-only level minimum, maximum and step.
// - Input evaluated once per sample.
// - Level mode triggers on entry or start.
`timescale 1ns/1ps

module eatd_top
	import eatd_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int LVL_STEP_MV = `EATD_LVL_STEP_MV
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Avalon-MM slave, byte addressed.
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Trigger input samples in millivolts, one per valid strobe.
	input wire logic signed [SAMPLE_W-1:0] sample_mv,
	input wire logic sample_valid,
	// Trigger results.
	output logic trig_event,
	output logic trig_gate,
	output logic term_50ohm,
	output logic irq
);

	// ****************************************************************
	// Elaboration checks.
	// ****************************************************************

	// The sample must hold the full level range and the step must be positive.
	if (SAMPLE_W < 14 || SAMPLE_W > 32) begin : g_bad_width
		$error("SAMPLE_W must lie between 14 and 32.");
	end
	if (LVL_STEP_MV < 1) begin : g_bad_step
		$error("LVL_STEP_MV must be at least one.");
	end

	// ****************************************************************
	// Functions.
	// ****************************************************************

	// True for exactly the defined mode encodings.
	function automatic logic mode_is_valid(input logic [31:0] value);
		mode_is_valid = (value == `EATD_MODE_DISABLED) || (value == `EATD_MODE_RISING) ||
			(value == `EATD_MODE_FALLING) || (value == `EATD_MODE_ANY) ||
			(value == `EATD_MODE_ABOVE) || (value == `EATD_MODE_BELOW);
	endfunction

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] lanes);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = new_value[i*8 +: 8];
			end
		end
		merge_bytes = result;
	endfunction

	// ****************************************************************
	// Declarations.
	// ****************************************************************

	logic served_reg;
	logic access_go;
	logic write_go;
	logic [15:0] reg_index;
	logic addr_aligned;
	logic [31:0] read_next;
	logic [31:0] wr_merged;
	logic [31:0] term_reg;
	logic [31:0] or_mask_reg;
	logic [31:0] and_mask_reg;
	eatd_mode_t mode_reg;
	logic signed [31:0] level_reg;
	logic signed [31:0] level_next;
	logic [31:0] control_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic [1:0] irq_set;
	logic [1:0] irq_clear;
	logic bad_mode_write;
	logic arm_rise;
	logic arm_prev_reg;
	logic first_reg;
	logic above_now;
	logic above_prev_reg;
	logic input_enabled;
	logic hit_next;
	logic gate_next;

	// ****************************************************************
	// Avalon-MM handshake.
	// ****************************************************************

	// Each access answers one cycle after it arrives; read data are latched in the first cycle, writes take effect in the answer cycle.
	assign avs_waitrequest = (avs_read || avs_write) && !served_reg;
	assign access_go = (avs_read || avs_write) && !served_reg;
	assign write_go = avs_write && served_reg;
	assign reg_index = avs_address[17:2];
	assign addr_aligned = (avs_address[1:0] == 2'b00);

	// Tracks the answer cycle of a pending access.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			served_reg <= 1'b0;
		end else begin
			served_reg <= access_go;
		end
	end

	// ****************************************************************
	// Read decode.
	// ****************************************************************

	// Unmapped and misaligned addresses read as zero.
	always_comb begin
		read_next = `EATD_RST_ZERO;
		if (addr_aligned) begin
			case (reg_index)
				`EATD_IDX_TERM: read_next = term_reg;
				`EATD_IDX_OR_MASK: read_next = or_mask_reg;
				`EATD_IDX_AND_MASK: read_next = and_mask_reg;
				`EATD_IDX_MODES: read_next = `EATD_SUPPORTED_MODES;
				`EATD_IDX_MODE: read_next = mode_reg;
				`EATD_IDX_LEVEL: read_next = level_reg;
				`EATD_IDX_LVL_MIN: read_next = 32'(`EATD_LVL_MIN_MV);
				`EATD_IDX_LVL_MAX: read_next = 32'(`EATD_LVL_MAX_MV);
				`EATD_IDX_LVL_STEP: read_next = 32'(LVL_STEP_MV);
				`EATD_IDX_CONTROL: read_next = control_reg;
				`EATD_IDX_STATE: read_next = {28'h000_0000, first_reg, input_enabled, trig_gate, above_prev_reg};
				`EATD_IDX_IRQ_STATUS: read_next = {30'h0000_0000, irq_status_reg};
				`EATD_IDX_IRQ_MASK: read_next = {30'h0000_0000, irq_mask_reg};
				default: read_next = `EATD_RST_ZERO;
			endcase
		end
	end

	// Read data is captured in the waiting cycle and stands at the answer edge.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= `EATD_RST_ZERO;
		end else if (access_go && avs_read) begin
			avs_readdata <= read_next;
		end
	end

	// ****************************************************************
	// Writable registers.
	// ****************************************************************

	assign wr_merged = merge_bytes(read_next, avs_writedata, avs_byteenable);

	// A written level outside the range is clamped to the nearest limit.
	always_comb begin
		level_next = wr_merged;
		if ($signed(wr_merged) < $signed(32'(`EATD_LVL_MIN_MV))) begin
			level_next = 32'(`EATD_LVL_MIN_MV);
		end else if ($signed(wr_merged) > $signed(32'(`EATD_LVL_MAX_MV))) begin
			level_next = 32'(`EATD_LVL_MAX_MV);
		end
	end

	// Termination select, drives the input stage directly.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			term_reg <= `EATD_RST_TERM;
		end else if (write_go && addr_aligned && reg_index == `EATD_IDX_TERM) begin
			term_reg <= {31'h0000_0000, wr_merged[0]};
		end
	end

	assign term_50ohm = term_reg[0];

	// Trigger OR and AND masks; only the external input bit matters here.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			or_mask_reg <= `EATD_RST_MASK;
			and_mask_reg <= `EATD_RST_MASK;
		end else if (write_go && addr_aligned) begin
			if (reg_index == `EATD_IDX_OR_MASK) begin
				or_mask_reg <= wr_merged;
			end
			if (reg_index == `EATD_IDX_AND_MASK) begin
				and_mask_reg <= wr_merged;
			end
		end
	end

	// A write of an undefined mode code leaves the old mode in place.
	assign bad_mode_write = write_go && addr_aligned && reg_index == `EATD_IDX_MODE && !mode_is_valid(wr_merged);

	// Mode register holds exactly one defined behaviour.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= mode_disabled;
		end else if (write_go && addr_aligned && reg_index == `EATD_IDX_MODE && mode_is_valid(wr_merged)) begin
			mode_reg <= eatd_mode_t'(wr_merged);
		end
	end

	// Trigger level in millivolts, held within its limits.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_reg <= `EATD_RST_LEVEL;
		end else if (write_go && addr_aligned && reg_index == `EATD_IDX_LEVEL) begin
			level_reg <= level_next;
		end
	end

	// Control register carries the arm bit that starts an acquisition.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= `EATD_RST_ZERO;
		end else if (write_go && addr_aligned && reg_index == `EATD_IDX_CONTROL) begin
			control_reg <= {31'h0000_0000, wr_merged[`EATD_CTRL_ARM_BIT]};
		end
	end

	// ****************************************************************
	// Detection.
	// ****************************************************************

	// The input takes part only with a live mode and its mask bit set.
	assign input_enabled = (mode_reg != mode_disabled) &&
		(or_mask_reg[`EATD_MASK_EXT_BIT] || and_mask_reg[`EATD_MASK_EXT_BIT]);

	// Comparator: sample against the programmed level, sample sign extended to 32 bits.
	assign above_now = 32'($signed(sample_mv)) > level_reg;

	assign arm_rise = control_reg[`EATD_CTRL_ARM_BIT] && !arm_prev_reg;

	// Remembers the arm bit to find the start of an acquisition.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_prev_reg <= 1'b0;
		end else begin
			arm_prev_reg <= control_reg[`EATD_CTRL_ARM_BIT];
		end
	end

	// Marks the first sample after arming, which has no valid predecessor.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_reg <= 1'b1;
		end else if (arm_rise) begin
			first_reg <= 1'b1;
		end else if (sample_valid) begin
			first_reg <= 1'b0;
		end
	end

	// Keeps the previous comparator result, updated once per sample.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			above_prev_reg <= 1'b0;
		end else if (sample_valid) begin
			above_prev_reg <= above_now;
		end
	end

	// Selects the qualifying change or level for the current mode.
	always_comb begin
		hit_next = 1'b0;
		gate_next = trig_gate;
		if (sample_valid) begin
			gate_next = 1'b0;
			case (mode_reg)
				mode_rising_edge: hit_next = !first_reg && above_now && !above_prev_reg;
				mode_falling_edge: hit_next = !first_reg && !above_now && above_prev_reg;
				mode_any_edge: hit_next = !first_reg && (above_now != above_prev_reg);
				mode_above_level: begin
					gate_next = above_now;
					hit_next = above_now && (first_reg || !above_prev_reg);
				end
				mode_below_level: begin
					gate_next = !above_now;
					hit_next = !above_now && (first_reg || above_prev_reg);
				end
				default: begin
					hit_next = 1'b0;
					gate_next = 1'b0;
				end
			endcase
			hit_next = hit_next && input_enabled && control_reg[`EATD_CTRL_ARM_BIT];
			gate_next = gate_next && input_enabled;
		end
		if (!input_enabled) begin
			gate_next = 1'b0;
		end
	end

	// Registered event pulse and gate level.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_event <= 1'b0;
			trig_gate <= 1'b0;
		end else begin
			trig_event <= hit_next;
			trig_gate <= gate_next;
		end
	end

	// ****************************************************************
	// Interrupts.
	// ****************************************************************

	assign irq_set = {bad_mode_write, hit_next};
	assign irq_clear = (write_go && addr_aligned && reg_index == `EATD_IDX_IRQ_STATUS && avs_byteenable[0]) ?
		avs_writedata[1:0] : 2'b00;

	// Sticky status, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= 2'b00;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
		end
	end

	// Interrupt mask of the same layout as the status.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_reg <= 2'b00;
		end else if (write_go && addr_aligned && reg_index == `EATD_IDX_IRQ_MASK && avs_byteenable[0]) begin
			irq_mask_reg <= avs_writedata[1:0];
		end
	end

	// Level interrupt while any enabled status bit is set.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_status_reg & ~irq_clear | irq_set) & irq_mask_reg);
		end
	end

endmodule

// File: eatd_map.svh
// Register map, field positions, reset values and limits of the external analog trigger detector.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef EATD_MAP_SVH
`define EATD_MAP_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define EATD_IDX_TERM 16'h9cae
`define EATD_IDX_OR_MASK 16'h9dda
`define EATD_IDX_AND_MASK 16'h9dee
`define EATD_IDX_MODES 16'h9e34
`define EATD_IDX_MODE 16'h9e3e
`define EATD_IDX_LEVEL 16'ha550
`define EATD_IDX_LVL_MIN 16'ha564
`define EATD_IDX_LVL_MAX 16'ha565
`define EATD_IDX_LVL_STEP 16'ha566
`define EATD_IDX_CONTROL 16'hc000
`define EATD_IDX_STATE 16'hc001
`define EATD_IDX_IRQ_STATUS 16'hc002
`define EATD_IDX_IRQ_MASK 16'hc003

// ****************************************************************
// Mode encodings and the bitmask of supported modes.
// ****************************************************************
`define EATD_MODE_DISABLED 32'h0000_0000
`define EATD_MODE_RISING 32'h0000_0001
`define EATD_MODE_FALLING 32'h0000_0002
`define EATD_MODE_ANY 32'h0000_0004
`define EATD_MODE_ABOVE 32'h0000_0008
`define EATD_MODE_BELOW 32'h0000_0010
`define EATD_SUPPORTED_MODES 32'h0000_001f

// ****************************************************************
// Field positions.
// ****************************************************************
`define EATD_MASK_EXT_BIT 1
`define EATD_CTRL_ARM_BIT 0
`define EATD_IRQ_TRIG_BIT 0
`define EATD_IRQ_BADMODE_BIT 1

// ****************************************************************
// Reset values and level limits in millivolts.
// ****************************************************************
`define EATD_RST_TERM 32'h0000_0000
`define EATD_RST_MASK 32'h0000_0000
`define EATD_RST_LEVEL 32'h0000_0000
`define EATD_RST_ZERO 32'h0000_0000
`define EATD_LVL_MIN_MV (-5000)
`define EATD_LVL_MAX_MV 5000
`define EATD_LVL_STEP_MV 1

`endif

// File: eatd_pkg.sv
// Types shared by the external analog trigger detector.
// Assumes eatd_map.svh is on the include path.
`include "eatd_map.svh"

package eatd_pkg;
	// Detection behaviours selected by the mode register.
	typedef enum logic [31:0] {
		mode_disabled = `EATD_MODE_DISABLED,
		mode_rising_edge = `EATD_MODE_RISING,
		mode_falling_edge = `EATD_MODE_FALLING,
		mode_any_edge = `EATD_MODE_ANY,
		mode_above_level = `EATD_MODE_ABOVE,
		mode_below_level = `EATD_MODE_BELOW
	} eatd_mode_t;
endpackage

// File: eatd_properties.sv
// Checker for the external analog trigger detector, bound to eatd_top.
// Assumes the master holds each request until waitrequest is seen low.
`timescale 1ns/1ps
`include "eatd_map.svh"
module eatd_checker
	import eatd_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int LVL_STEP_MV = 1
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register bus.
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Samples and results.
	input wire logic signed [SAMPLE_W-1:0] sample_mv,
	input wire logic sample_valid,
	input wire logic trig_event,
	input wire logic trig_gate,
	input wire logic term_50ohm,
	input wire logic irq
);
	// ****************************************************************
	// Bus steps and properties.
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd(logic [15:0] idx);
		avs_read && !avs_waitrequest && avs_address == {idx, 2'b00};
	endsequence
	sequence s_wr(logic [15:0] idx);
		avs_write && !avs_waitrequest && avs_address == {idx, 2'b00} && avs_byteenable[0];
	endsequence
	a_modes_bitmask_ro: assert property (s_rd(`EATD_IDX_MODES) |-> avs_readdata == 32'h0000_001f)
		else $error("Supported mode mask is wrong.");
	a_mode_value_legal: assert property (s_rd(`EATD_IDX_MODE) |->
		avs_readdata inside {32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008, 32'h0000_0010})
		else $error("Mode register holds an undefined code.");
	a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Bus answer did not come after one wait cycle.");
	a_wait_first_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("Bus answered without a wait cycle.");
	a_level_in_limits: assert property (s_rd(`EATD_IDX_LEVEL) |->
		$signed(avs_readdata) >= -5000 && $signed(avs_readdata) <= 5000) else $error("Level out of limits.");
	a_level_min_value: assert property (s_rd(`EATD_IDX_LVL_MIN) |-> avs_readdata == 32'hffff_ec78)
		else $error("Level minimum is wrong.");
	a_level_max_value: assert property (s_rd(`EATD_IDX_LVL_MAX) |-> avs_readdata == 32'h0000_1388)
		else $error("Level maximum is wrong.");
	a_level_step_value: assert property (s_rd(`EATD_IDX_LVL_STEP) |-> avs_readdata == 32'(LVL_STEP_MV))
		else $error("Level step is wrong.");
	a_term_follows_write: assert property (s_wr(`EATD_IDX_TERM) |=> term_50ohm == $past(avs_writedata[0]))
		else $error("Termination output does not follow its write.");
	a_event_after_sample: assert property (trig_event |-> $past(sample_valid))
		else $error("Detection without a sample.");
	a_gate_entry_fires: assert property ($rose(trig_gate) |-> $past(sample_valid) && trig_event)
		else $error("Level entry without a detection.");
endmodule
bind eatd_top eatd_checker #(.SAMPLE_W(SAMPLE_W), .LVL_STEP_MV(LVL_STEP_MV)) i_chk (.sys_clk(sys_clk),
	.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sample_mv(sample_mv), .sample_valid(sample_valid),
	.trig_event(trig_event), .trig_gate(trig_gate), .term_50ohm(term_50ohm), .irq(irq));

// File: eatd_source.sv
// Model of the analog trigger source feeding converted samples in millivolts.
// Assumes a noise word from the bench each cycle.
`timescale 1ns/1ps
module eatd_source #(
	parameter int SAMPLE_W = 16
) (
	// Clock and control.
	input wire logic sys_clk,
	input wire logic run,
	input wire logic gaps,
	input wire logic [31:0] noise,
	// Sample stream.
	output logic signed [SAMPLE_W-1:0] sample_mv,
	output logic sample_valid
);
	int v;
	initial sample_valid = 1'b0;
	initial sample_mv = '0;
	// Odd values only, so a sample never equals the even level; idle lines toggle so stale data never holds.
	always @(posedge sys_clk) begin
		v = (int'(noise[10:1]) - 512) | 1;
		if (run) begin
			sample_valid <= !gaps || noise[0];
			sample_mv <= SAMPLE_W'(v);
		end else begin
			sample_valid <= 1'b0;
			sample_mv <= ~sample_mv;
		end
	end
endmodule

// File: eatd_top_test.sv
// Self-checking bench for eatd_top with a register mirror and a detection model.
// Assumes the map header and package are compiled first.
`timescale 1ns/1ps
`include "eatd_map.svh"
module eatd_top_test
	import eatd_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [17:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, trig_event, trig_gate, term_50ohm, irq, sample_valid;
	logic signed [15:0] sample_mv;
	logic run = 1'b0;
	logic gaps = 1'b0;
	logic [31:0] rnd = 32'h0000_d53a;
	logic [31:0] q;
	int miscompares = 0, compares = 0, cycles = 0, m_lvl = 0, lvl;
	logic [31:0] m_mode = '0, m_or = '0, m_and = '0, m_st = '0, m_msk = '0;
	logic m_arm = 1'b0, m_term = 1'b0, first = 1'b1, prev = 1'b0, ab, inl, exp_ev = 1'b0, exp_gate = 1'b0;
	logic [31:0] modes [6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008, 32'h0000_0010};
	eatd_top #(.SAMPLE_W(16), .LVL_STEP_MV(1)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_mv(sample_mv),
		.sample_valid(sample_valid), .trig_event(trig_event), .trig_gate(trig_gate), .term_50ohm(term_50ohm), .irq(irq));
	eatd_source #(.SAMPLE_W(16)) i_src (.sys_clk(sys_clk), .run(run), .gaps(gaps), .noise(rnd),
		.sample_mv(sample_mv), .sample_valid(sample_valid));
	// The clock toggles every half period of 2.5 ns.
	always #2.5 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic cur_en();
		return m_mode != 0 && (m_or[1] || m_and[1]) && m_arm;
	endfunction
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One bus access: hold the request until waitrequest is seen low at a rising edge.
	task automatic bus_go(input logic [15:0] idx, input logic wr, input logic [31:0] d);
		logic ws;
		ws = 1'b1;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		while (ws) begin
			#1;
			ws = avs_waitrequest;
			q = avs_readdata;
			@(posedge sys_clk);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	// A write also updates the mirror the way the device must take it.
	task automatic reg_wr(input logic [15:0] idx, input logic [31:0] d);
		bus_go(idx, 1'b1, d);
		case (idx)
			`EATD_IDX_MODE: if (d inside {modes}) m_mode = d; else m_st[1] = 1'b1;
			`EATD_IDX_LEVEL: m_lvl = ($signed(d) > 5000) ? 5000 : (($signed(d) < -5000) ? -5000 : $signed(d));
			`EATD_IDX_OR_MASK: m_or = d;
			`EATD_IDX_AND_MASK: m_and = d;
			`EATD_IDX_CONTROL: m_arm = d[0];
			`EATD_IDX_IRQ_STATUS: m_st = m_st & ~d;
			`EATD_IDX_IRQ_MASK: m_msk = d;
			`EATD_IDX_TERM: m_term = d[0];
			default: ;
		endcase
	endtask
	task automatic reg_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
		bus_go(idx, 1'b0, 32'h0000_0000);
		check(name, q, exp);
	endtask
	// Detection model: evaluates each strobed sample as the device must.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			final_report();
		end
		rnd <= xs(rnd);
		exp_ev = 1'b0;
		if (!cur_en()) begin
			first = 1'b1;
		end else if (sample_valid) begin
			ab = int'(sample_mv) > m_lvl;
			inl = (m_mode == 8) ? ab : !ab;
			if (first) exp_ev = (m_mode >= 8) && inl;
			else exp_ev = (m_mode == 4) ? (ab != prev) : ((m_mode == 1 || m_mode == 8) ? (ab && !prev) : (!ab && prev));
			exp_gate = (m_mode >= 8) && inl;
			prev = ab;
			first = 1'b0;
			if (exp_ev) m_st[0] = 1'b1;
		end
	end
	// Results are compared at each falling edge; trig_gate only while enabled and armed and after the first sample.
	always @(negedge sys_clk) begin
		if (rst_n) check("trig_event", 32'(trig_event), 32'(exp_ev));
		if (rst_n && cur_en() && !first) check("trig_gate", 32'(trig_gate), 32'(exp_gate));
	end
	// Main sequence.
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		reg_chk("modes", `EATD_IDX_MODES, 32'h0000_001f);
		reg_chk("mode", `EATD_IDX_MODE, 32'h0000_0000);
		reg_chk("term", `EATD_IDX_TERM, 32'h0000_0000);
		reg_chk("level", `EATD_IDX_LEVEL, 32'h0000_0000);
		reg_chk("or", `EATD_IDX_OR_MASK, 32'h0000_0000);
		reg_chk("unmapped", 16'h0001, 32'h0000_0000);
		reg_wr(`EATD_IDX_MODES, 32'h0000_0000);
		reg_chk("modes", `EATD_IDX_MODES, 32'h0000_001f);
		reg_wr(`EATD_IDX_LVL_MIN, 32'h0000_0000);
		reg_chk("min", `EATD_IDX_LVL_MIN, 32'hffff_ec78);
		reg_chk("max", `EATD_IDX_LVL_MAX, 32'h0000_1388);
		reg_chk("step", `EATD_IDX_LVL_STEP, 32'h0000_0001);
		for (int t = 1; t >= 0; t--) begin
			reg_wr(`EATD_IDX_TERM, 32'(t));
			check("term_50ohm", 32'(term_50ohm), 32'(t));
			reg_chk("term", `EATD_IDX_TERM, 32'(m_term));
		end
		foreach (modes[i]) begin
			reg_wr(`EATD_IDX_LEVEL, 32'(6000 - 13000 * i));
			reg_chk("level", `EATD_IDX_LEVEL, 32'(m_lvl));
		end
		// Each mode with the OR mask, the AND mask, then neither.
		foreach (modes[i]) begin
			for (int k = 0; k < 3; k++) begin
				lvl = int'(rnd[8:0]) - 256;
				reg_wr(`EATD_IDX_CONTROL, 32'h0000_0000);
				reg_wr(`EATD_IDX_MODE, modes[i]);
				reg_wr(`EATD_IDX_LEVEL, 32'(lvl - (lvl & 1)));
				reg_wr(`EATD_IDX_OR_MASK, (k == 0) ? 32'h0000_0002 : 32'h0000_0001);
				reg_wr(`EATD_IDX_AND_MASK, (k == 1) ? 32'h0000_0002 : 32'h0000_0000);
				reg_wr(`EATD_IDX_CONTROL, 32'h0000_0001);
				gaps <= rnd[3];
				run <= 1'b1;
				repeat (60) @(posedge sys_clk);
				run <= 1'b0;
				repeat (2) @(posedge sys_clk);
				reg_chk("mode", `EATD_IDX_MODE, modes[i]);
				reg_chk("irq_status", `EATD_IDX_IRQ_STATUS, m_st);
			end
		end
		reg_wr(`EATD_IDX_MODE, 32'h0000_0003);
		reg_chk("mode", `EATD_IDX_MODE, m_mode);
		reg_chk("irq_status", `EATD_IDX_IRQ_STATUS, m_st);
		reg_wr(`EATD_IDX_IRQ_MASK, 32'h0000_0001);
		repeat (3) @(posedge sys_clk);
		check("irq", 32'(irq), 32'(|(m_st & m_msk)));
		reg_wr(`EATD_IDX_IRQ_STATUS, 32'h0000_0003);
		repeat (3) @(posedge sys_clk);
		check("irq", 32'(irq), 32'h0000_0000);
		reg_chk("irq_status", `EATD_IDX_IRQ_STATUS, 32'h0000_0000);
		final_report();
	end
endmodule
